// ==== src/pnfs_config_regs.sv ====
/*
 Partial-networking rate/filter and CAN configuration, wake pulse width,
 fail-safe counter, limp output control and status, and the two-step soft
 system reset, plus the idle-detection bit filter steered by them.
 Assumes the serial port decoder hands over one-cycle strobes on mclk, and
 that the host keeps reserved bits at zero on write.
*/
`timescale 1ns/10ps
`include "pnfs_defines.svh"

module pnfs_config_regs (
	input  wire logic              mclk,               // 40 MHz system clock
	input  wire logic              nrst,               // Async reset, active low
	input  wire pnfs_pkg::pnfs_req_t req,              // Register access strobe
	input  wire pnfs_pkg::pnfs_evt_t evt,              // Mode events, one-cycle pulses
	input  wire logic              limp_out_level_pin, // Sensed limp pin level
	input  wire logic              bus_rxd_pin,        // Bus receive level, low dominant
	output logic [7:0]             rdata,              // Read data, valid after rd
	output logic                   limp_out_pin_n_out, // Limp pin output value
	output logic                   limp_out_pin_n_oe,  // Limp pin output enable
	output logic                   selective_wake_core,// Core enabled
	output logic                   selective_wake_act, // Selective wake-up active
	output logic                   std_wake_only,      // Standard pattern wake only
	output logic                   fd_count_en,        // FD frames count errors
	output logic                   wake_pulse_width_sel,// Long wake time when high
	output logic                   bus_activity,       // Filtered pulse detected
	output logic                   sys_reset_req       // Soft reset, one-cycle pulse
);
	localparam int CW = 10;

	logic [3:0]  idle_filter_sel_reg;
	logic [2:0]  arb_rate_sel_reg;
	logic        fd_err_count_ctrl_reg;
	logic        sw_config_valid_reg;
	logic        selective_wake_en_reg;
	logic        wake_pulse_width_sel_reg;
	logic [1:0]  failsafe_count_reg;
	logic [1:0]  limp_out_ctrl_reg;
	logic [7:0]  rdata_reg;
	logic        reset_pulse_reg;
	logic        activity_reg;
	logic [1:0]  limp_sync_reg;
	logic [1:0]  rxd_sync_reg;
	logic        rxd_prev_reg;
	logic [CW-1:0] low_cnt_reg;
	pnfs_pkg::pnfs_rst_state_t rst_state_reg;

	// Bit time in clocks for a rate code
	function automatic logic [CW-1:0] bit_clocks(input logic [2:0] code);
		int kbps;
		kbps = `PNFS_KBPS_4;
		unique case (code)
			3'h0: kbps = `PNFS_KBPS_0;
			3'h1: kbps = `PNFS_KBPS_1;
			3'h2: kbps = `PNFS_KBPS_2;
			3'h3: kbps = `PNFS_KBPS_3;
			3'h4: kbps = `PNFS_KBPS_4;
			3'h5: kbps = `PNFS_KBPS_5;
			3'h6: kbps = `PNFS_KBPS_4;
			3'h7: kbps = `PNFS_KBPS_7;
		endcase
		return CW'(`PNFS_MCLK_KHZ / kbps);
	endfunction

	// Register hit decode, used by the write and the read paths
	function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
		return a == target;
	endfunction

	// Detect limit: a low pulse must last more than this many clocks
	wire logic [CW-1:0] bt_clk = bit_clocks(arb_rate_sel_reg);
	wire logic [CW-1:0] thr_wide = CW'((32'(bt_clk) * `PNFS_DET_WIDE_PM) / `PNFS_PM_DIV); // see [R2]
	wire logic [CW-1:0] thr_narrow = CW'((32'(bt_clk) * `PNFS_DET_NARROW_PM) / `PNFS_NARROW_DIV); // see [R3]
	logic [CW-1:0] det_thr;
	always_comb begin
		det_thr = '0;
		unique case (idle_filter_sel_reg)
			4'h0, 4'h1: det_thr = thr_wide;                                    // see [R2]
			4'h2: det_thr = thr_narrow;                                        // see [R3]
			4'h3: det_thr = CW'(`PNFS_DET3_NS / `PNFS_MCLK_NS);                // see [R4]
			4'h4: det_thr = CW'(`PNFS_DET4_NS / `PNFS_MCLK_NS);                // see [R4]
			4'h5: det_thr = CW'(`PNFS_DET5_NS / `PNFS_MCLK_NS);                // see [R4]
			4'h6: det_thr = CW'(`PNFS_DET6_NS / `PNFS_MCLK_NS);                // see [R4]
			default: det_thr = '1;
		endcase
	end
	// Pulses under the ignore limit never reach the detect limit, so one compare serves both
	wire logic filt_ok = idle_filter_sel_reg <= `PNFS_FILT_MAX;                 // see [R1]
	wire logic core_on = arb_rate_sel_reg != `PNFS_RATE_OFF;                    // see [R5]
	// A low pulse is counted only behind the second sync flop, so it is seen two clocks late
	wire logic rxd = rxd_sync_reg[1];
	wire logic low_end = rxd && !rxd_prev_reg;
	wire logic activity_next = low_end && filt_ok && core_on && (low_cnt_reg > det_thr);
	wire logic [CW-1:0] low_cnt_next = rxd ? '0 : ((&low_cnt_reg) ? low_cnt_reg : low_cnt_reg + 1'b1);

	wire logic wr_rate = req.wr && hit(req.addr, `PNFS_ADDR_RATE_FILT);
	wire logic wr_can  = req.wr && hit(req.addr, `PNFS_ADDR_CAN_CFG);
	wire logic wr_wake = req.wr && hit(req.addr, `PNFS_ADDR_WAKE_CFG);
	wire logic wr_fs   = req.wr && hit(req.addr, `PNFS_ADDR_FS_CNT);
	wire logic wr_limp = req.wr && hit(req.addr, `PNFS_ADDR_LIMP_CTRL);
	wire logic wr_rst  = req.wr && hit(req.addr, `PNFS_ADDR_SOFT_RST);

	// Hardware events outrank a host write in the same cycle
	// The counter saturates at three rather than wrapping back to zero
	wire logic [1:0] failsafe_count_next =
		evt.failsafe_entry ? 2'h0 :                                           // see [R9]
		evt.count_incr ? ((&failsafe_count_reg) ? failsafe_count_reg : failsafe_count_reg + 2'h1) :
		wr_fs ? req.wdata[7:6] : failsafe_count_reg;                          // see [R9]

	wire logic limp_high = limp_out_ctrl_reg[1];
	wire logic [1:0] limp_out_ctrl_next =
		evt.off_entry ? `PNFS_LIMP_HIZ :                                      // see [R11]
		(evt.failsafe_entry || evt.boot_fail_entry) ? `PNFS_LIMP_LOW :        // see [R11]
		((evt.boot_done || evt.count_incr) && limp_high) ? `PNFS_LIMP_HIZ :   // see [R12]
		wr_limp ? req.wdata[1:0] : limp_out_ctrl_reg;

	// Any write that is not an arm write drops the armed state, the confirm included
	wire logic confirm = wr_rst && req.wdata == `PNFS_RST_CONFIRM && rst_state_reg == pnfs_pkg::PNFS_RST_ARMED;
	pnfs_pkg::pnfs_rst_state_t rst_state_next;
	always_comb begin
		rst_state_next = rst_state_reg;
		if (req.wr) begin
			rst_state_next = (wr_rst && req.wdata == `PNFS_RST_ARM) ?       // see [R14]
				pnfs_pkg::PNFS_RST_ARMED : pnfs_pkg::PNFS_RST_IDLE;       // see [R17]
		end
	end

	// Reserved bits are simply not stored and read back as zero
	// Read data is latched on the strobe and held, so a slow host may fetch it late
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;                                                       // see [R18]
		if (hit(req.addr, `PNFS_ADDR_RATE_FILT))
			rd_mux = {idle_filter_sel_reg, 1'b0, arb_rate_sel_reg};
		else if (hit(req.addr, `PNFS_ADDR_CAN_CFG))
			rd_mux = {5'h00, fd_err_count_ctrl_reg, sw_config_valid_reg, selective_wake_en_reg};
		else if (hit(req.addr, `PNFS_ADDR_WAKE_CFG))
			rd_mux = {7'h00, wake_pulse_width_sel_reg};
		else if (hit(req.addr, `PNFS_ADDR_LIMP_STAT))
			rd_mux = {7'h00, limp_sync_reg[1]};                           // see [R13]
		else if (hit(req.addr, `PNFS_ADDR_FS_CNT))
			rd_mux = {failsafe_count_reg, 6'h00};
		else if (hit(req.addr, `PNFS_ADDR_LIMP_CTRL))
			rd_mux = {6'h00, limp_out_ctrl_reg};
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			idle_filter_sel_reg      <= `PNFS_FILT_RST;
			arb_rate_sel_reg         <= `PNFS_RATE_RST;                    // see [R5]
			fd_err_count_ctrl_reg    <= 1'b0;                              // see [R6]
			sw_config_valid_reg      <= 1'b0;                              // see [R7]
			selective_wake_en_reg    <= 1'b0;                              // see [R8]
			wake_pulse_width_sel_reg <= 1'b0;                              // see [R15]
		end else begin
			if (wr_rate) begin
				idle_filter_sel_reg <= req.wdata[7:4];                 // see [R1]
				arb_rate_sel_reg    <= req.wdata[2:0];                 // see [R5]
			end
			if (wr_can) begin
				fd_err_count_ctrl_reg <= req.wdata[2];                 // see [R6]
				sw_config_valid_reg   <= req.wdata[1];                 // see [R7]
				selective_wake_en_reg <= req.wdata[0];                 // see [R8]
			end
			if (wr_wake)
				wake_pulse_width_sel_reg <= req.wdata[0];              // see [R15]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			failsafe_count_reg <= 2'h0;
			limp_out_ctrl_reg  <= `PNFS_LIMP_HIZ;                          // see [R12]
			rst_state_reg      <= pnfs_pkg::PNFS_RST_IDLE;
			reset_pulse_reg    <= 1'b0;
			rdata_reg          <= 8'h00;
		end else begin
			failsafe_count_reg <= failsafe_count_next;
			limp_out_ctrl_reg  <= limp_out_ctrl_next;
			rst_state_reg      <= rst_state_next;
			reset_pulse_reg    <= confirm;                                 // see [R17]
			if (req.rd)
				rdata_reg <= rd_mux;
		end
	end

	// Pins from outside pass two flip-flops before any logic looks at them
	// rxd idles high after reset so that a release does not look like the end of a pulse
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			limp_sync_reg <= 2'b00;
			rxd_sync_reg  <= 2'b11;
			rxd_prev_reg  <= 1'b1;
			low_cnt_reg   <= '0;
			activity_reg  <= 1'b0;
		end else begin
			limp_sync_reg <= {limp_sync_reg[0], limp_out_level_pin};
			rxd_sync_reg  <= {rxd_sync_reg[0], bus_rxd_pin};
			rxd_prev_reg  <= rxd;
			low_cnt_reg   <= low_cnt_next;
			activity_reg  <= activity_next;
		end
	end

	// Output flops
	// Limp pin flops take the next control code so that pin and register change together
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			limp_out_pin_n_out   <= 1'b0;
			limp_out_pin_n_oe    <= 1'b0;
			selective_wake_core  <= 1'b0;
			selective_wake_act   <= 1'b0;
			std_wake_only        <= 1'b1;
			fd_count_en          <= 1'b1;
			wake_pulse_width_sel <= 1'b0;
		end else begin
			limp_out_pin_n_out   <= limp_out_ctrl_next[1];                 // see [R10]
			limp_out_pin_n_oe    <= |limp_out_ctrl_next;                   // see [R10]
			selective_wake_core  <= core_on;                               // see [R5]
			selective_wake_act   <= core_on && sw_config_valid_reg && selective_wake_en_reg; // see [R8]
			std_wake_only        <= !sw_config_valid_reg || !core_on;      // see [R7]
			fd_count_en          <= !fd_err_count_ctrl_reg;                // see [R6]
			wake_pulse_width_sel <= wake_pulse_width_sel_reg;              // see [R15]
		end
	end

	assign rdata         = rdata_reg;
	assign sys_reset_req = reset_pulse_reg;
	assign bus_activity  = activity_reg;

	sequence s_arm;
		req.wr && req.addr == `PNFS_ADDR_SOFT_RST && req.wdata == `PNFS_RST_ARM;
	endsequence
	sequence s_confirm;
		req.wr && req.addr == `PNFS_ADDR_SOFT_RST && req.wdata == `PNFS_RST_CONFIRM;
	endsequence
	// A read or an idle cycle between the two writes keeps the arm alive
	sequence s_no_write;
		!req.wr;
	endsequence
	// Increment that the fail-safe entry does not override
	sequence s_count_step;
		evt.count_incr && !evt.failsafe_entry;
	endsequence
	// Increment event that must drop a drive-high limp code
	sequence s_limp_high_incr;
		limp_high && evt.count_incr && !evt.off_entry && !evt.failsafe_entry && !evt.boot_fail_entry;
	endsequence

	AST_SOFT_RESET_PAIR: assert property (@(posedge mclk) disable iff (!nrst) // see [R14]
		s_arm ##1 s_no_write ##1 s_confirm |=> sys_reset_req)
		else $error("Arm then confirm gave no reset pulse");
	AST_SOFT_RESET_CAUSE: assert property (@(posedge mclk) disable iff (!nrst) // see [R17]
		sys_reset_req |-> $past(confirm))
		else $error("Reset pulse without a confirm right after arm");
	AST_FS_COUNT_ZERO: assert property (@(posedge mclk) disable iff (!nrst) // see [R9]
		evt.failsafe_entry |=> failsafe_count_reg == 2'h0)
		else $error("Fail-safe counter not cleared on fail-safe entry");
	AST_LIMP_FS_LOW: assert property (@(posedge mclk) disable iff (!nrst) // see [R11]
		(evt.failsafe_entry && !evt.off_entry) |=> limp_out_pin_n_oe && !limp_out_pin_n_out)
		else $error("Limp pin not driven low after fail-safe entry");
	AST_LIMP_OFF_HIZ: assert property (@(posedge mclk) disable iff (!nrst) // see [R11]
		evt.off_entry |=> !limp_out_pin_n_oe && limp_out_ctrl_reg == `PNFS_LIMP_HIZ)
		else $error("Limp pin not released after Off entry");
	AST_LIMP_HIGH_CLEAR: assert property (@(posedge mclk) disable iff (!nrst) // see [R12]
		(limp_high && evt.boot_done && !evt.failsafe_entry && !evt.boot_fail_entry)
		|=> limp_out_ctrl_reg == `PNFS_LIMP_HIZ)
		else $error("Limp code 1x kept after boot");
	AST_LIMP_PIN_MAP: assert property (@(posedge mclk) disable iff (!nrst) // see [R10]
		limp_out_pin_n_oe == (limp_out_ctrl_reg != `PNFS_LIMP_HIZ) &&
		limp_out_pin_n_out == limp_out_ctrl_reg[1])
		else $error("Limp pin does not follow its control code");
	AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!nrst) // see [R18]
		req.rd && req.addr == `PNFS_ADDR_CAN_CFG |=> rdata[7:3] == 5'h00)
		else $error("Reserved bits read nonzero");
	AST_CORE_OFF: assert property (@(posedge mclk) disable iff (!nrst) // see [R5]
		arb_rate_sel_reg == `PNFS_RATE_OFF |=> !selective_wake_core && !bus_activity)
		else $error("Core not disabled by reserved rate code");
	AST_WAKE_STD: assert property (@(posedge mclk) disable iff (!nrst) // see [R7]
		!sw_config_valid_reg |=> std_wake_only && !selective_wake_act)
		else $error("Selective wake active with invalid setup");

	// Outputs other than the limp pin and sys_reset_req follow a write two edges later: one into the register, one into the output flop
	AST_FS_COUNT_STEP: assert property (@(posedge mclk) disable iff (!nrst) // see [R9]
		s_count_step |=> failsafe_count_reg ==
			((&$past(failsafe_count_reg)) ? 2'h3 : 2'($past(failsafe_count_reg) + 2'h1)))
		else $error("Fail-safe counter did not step on an increment event");
	AST_LIMP_BOOTFAIL_LOW: assert property (@(posedge mclk) disable iff (!nrst) // see [R11]
		(evt.boot_fail_entry && !evt.off_entry) |=> limp_out_pin_n_oe && !limp_out_pin_n_out)
		else $error("Limp pin not driven low after boot-fail entry");
	AST_LIMP_INCR_CLEAR: assert property (@(posedge mclk) disable iff (!nrst) // see [R12]
		s_limp_high_incr |=> limp_out_ctrl_reg == `PNFS_LIMP_HIZ)
		else $error("Limp code 1x kept after a counter increment");
	AST_FILT_RESERVED: assert property (@(posedge mclk) disable iff (!nrst) // see [R1]
		idle_filter_sel_reg > `PNFS_FILT_MAX |=> !bus_activity)
		else $error("Activity detected with a reserved filter code");
	AST_FD_COUNT: assert property (@(posedge mclk) disable iff (!nrst) // see [R6]
		wr_can |-> ##2 fd_count_en != $past(req.wdata[2], 2))
		else $error("FD error count output does not follow its control bit");
	AST_WAKE_WIDTH: assert property (@(posedge mclk) disable iff (!nrst) // see [R15]
		wr_wake |-> ##2 wake_pulse_width_sel == $past(req.wdata[0], 2))
		else $error("Wake pulse width output does not follow its control bit");
endmodule

// ==== src/pnfs_defines.svh ====
/*
 Register map, field positions, reset values and timing constants of the
 partial-networking and fail-safe configuration slice.
 Assumes a 40 MHz mclk and a 12-bit register address from the serial port.
*/
// Functional notes
// [R1] Idle filter select is bits 7:4 of rate/filter; codes 0-6 valid, 7-15 reserved.
// [R2] Filters 0/1: ignore under 5.0 %, detect over 17.5 % of bit time.
// [R3] Filter 2: ignore under 2.5 %, detect over 8.75 % of bit time.
// [R4] Filters 3-6 use absolute limits 18/93, 42/119, 67/145, 91/170 ns.
// [R5] Bits 2:0 select bit rate; 100 is default; 110 disables the core.
// [R6] FD error count control, default 0: 0 counts FD frames, 1 does not.
// [R7] Config-valid bit 0 means invalid setup; wake only on standard pattern.
// [R8] Bit 0 of CAN config enables selective wake-up; default off.
// [R9] Two-bit fail-safe counter in bits 7:6, forced to zero on fail-safe entry.
// [R10] Limp control: 00 high-Z, 01 drive low, 1x drive high.
// [R11] Limp control loads 00 on Off entry, 01 on fail-safe or boot-fail entry.
// [R12] Limp codes 1x clear to 00 after boot, counter increment or reset.
// [R13] Read-only bit reports sensed limp pin level.
// [R14] Host arms soft reset with 01h then confirms with 80h.
// [R15] Wake pulse bit 0: 0 short (default), 1 long wake-up time.
// [R16] Host writes zeros to reserved bits 7:3 of CAN config and ignores them.
// [R17] Reset only when confirm directly follows arm; other writes disarm.
// [R18] Reserved bits read zero and ignore writes.
`ifndef PNFS_DEFINES_SVH
`define PNFS_DEFINES_SVH

`define PNFS_ADDR_RATE_FILT   12'h031
`define PNFS_ADDR_CAN_CFG     12'h032
`define PNFS_ADDR_WAKE_CFG    12'h040
`define PNFS_ADDR_LIMP_STAT   12'h076
`define PNFS_ADDR_FS_CNT      12'h090
`define PNFS_ADDR_LIMP_CTRL   12'h091
`define PNFS_ADDR_SOFT_RST    12'hfe0

`define PNFS_RST_ARM          8'h01
`define PNFS_RST_CONFIRM      8'h80

`define PNFS_FILT_RST         4'h0
`define PNFS_FILT_MAX         4'h6
`define PNFS_RATE_RST         3'h4
`define PNFS_RATE_OFF         3'h6
`define PNFS_LIMP_HIZ         2'h0
`define PNFS_LIMP_LOW         2'h1

// Clock period and bit rates (kbit/s) used to size the filters
`define PNFS_MCLK_NS          25
`define PNFS_MCLK_KHZ         40000
`define PNFS_KBPS_0           50
`define PNFS_KBPS_1           100
`define PNFS_KBPS_2           125
`define PNFS_KBPS_3           250
`define PNFS_KBPS_4           500
`define PNFS_KBPS_5           667
`define PNFS_KBPS_7           1000
// Detect fractions: wide in tenths, narrow in hundredths of a percent
`define PNFS_DET_WIDE_PM      175
`define PNFS_DET_NARROW_PM    875
`define PNFS_PM_DIV           1000
`define PNFS_NARROW_DIV       10000
// Absolute detect limits in ns
`define PNFS_DET3_NS          93
`define PNFS_DET4_NS          119
`define PNFS_DET5_NS          145
`define PNFS_DET6_NS          170

`endif

// ==== src/pnfs_pkg.sv ====
/*
 Types shared by the configuration slice.
 Assumes pnfs_defines.svh supplies all numeric constants.
*/
package pnfs_pkg;
	typedef struct packed {
		logic off_entry;          // Off mode entered
		logic failsafe_entry;     // Fail-safe state entered
		logic boot_fail_entry;    // Boot-fail state entered
		logic boot_done;          // Boot completed
		logic count_incr;         // Fail-safe counter increment event
	} pnfs_evt_t;

	typedef struct packed {
		logic        wr;          // Write strobe
		logic        rd;          // Read strobe
		logic [11:0] addr;        // Register address
		logic [7:0]  wdata;       // Write data
	} pnfs_req_t;

	typedef enum logic [1:0] {
		PNFS_RST_IDLE  = 2'b01,
		PNFS_RST_ARMED = 2'b10
	} pnfs_rst_state_t;
endpackage

// ==== test/pn_failsafe_config_regs_tb.sv ====
/*
 Self-checking bench: reset values, register access, mode events, soft reset
 and idle filter. Assumes the decoded strobe port and the pin model.
*/
`timescale 1ns/10ps
`include "pnfs_defines.svh"

module pn_failsafe_config_regs_tb;
	logic                mclk = 1'b0;
	logic                nrst = 1'b0;
	pnfs_pkg::pnfs_req_t req = '0;
	pnfs_pkg::pnfs_evt_t evt = '0;
	logic                pull = 1'b1;
	logic [8:0]          dom_clks = '0;
	logic                go = 1'b0;
	logic                lvl, rxd, oe, out, core, act, std, fdc, wsel, actv, srst;
	logic [7:0]          rdata, v, rf, cc, wk, lc, fc;
	int                  errors = 0, num_checks = 0, n_act = 0, n_rst = 0, r0;
	wire [7:0]           outs = {1'b0, core, act, std, fdc, wsel, oe, out & oe};
	localparam logic [11:0] AD [8] = '{`PNFS_ADDR_RATE_FILT, `PNFS_ADDR_CAN_CFG, `PNFS_ADDR_WAKE_CFG,
		`PNFS_ADDR_LIMP_STAT, `PNFS_ADDR_FS_CNT, `PNFS_ADDR_LIMP_CTRL, `PNFS_ADDR_SOFT_RST, 12'h123};
	localparam logic [7:0]  DF [8] = '{8'h04, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (actv === 1'b1) n_act++;
		if (srst === 1'b1) n_rst++;
	end

	pnfs_config_regs pnfs_config_regs_i (.mclk(mclk), .nrst(nrst), .req(req), .evt(evt),
		.limp_out_level_pin(lvl), .bus_rxd_pin(rxd), .rdata(rdata), .limp_out_pin_n_out(out),
		.limp_out_pin_n_oe(oe), .selective_wake_core(core), .selective_wake_act(act),
		.std_wake_only(std), .fd_count_en(fdc), .wake_pulse_width_sel(wsel), .bus_activity(actv),
		.sys_reset_req(srst));
	pnfs_pin_model pnfs_pin_model_i (.mclk(mclk), .nrst(nrst), .go(go), .dom_clks(dom_clks),
		.pin_out(out), .pin_oe(oe), .pull_lvl(pull), .limp_lvl(lvl), .rxd(rxd));

	task automatic stop_test;
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk) #1;
		req.wr = 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		@(posedge mclk) #1;
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk) #1;
		req.rd = 1'b0;
		check(rdata, e);
	endtask

	task automatic pulse(input logic [4:0] e);
		@(posedge mclk) #1;
		evt = pnfs_pkg::pnfs_evt_t'(e);
		@(posedge mclk) #1;
		evt = '0;
	endtask

	task automatic burst(input int n, input int exp);
		int a;
		a = n_act;
		@(posedge mclk) #1;
		dom_clks = 9'(n);
		go = 1'b1;
		@(posedge mclk) #1;
		go = 1'b0;
		repeat (n + 10) @(posedge mclk);
		check(8'(n_act - a), 8'(exp));
	endtask

	function automatic logic [7:0] exp_outs(input logic [7:0] r, c, w, l);
		logic k;
		k = r[2:0] != 3'h6;
		return {1'b0, k, k & c[1] & c[0], ~c[1] | ~k, ~c[2], w[0], l[1:0] != 2'h0, l[1]};
	endfunction

	function automatic int limit(input int f, input int r);
		int kb [8] = '{50, 100, 125, 250, 500, 667, 1, 1000};
		int bt;
		bt = `PNFS_MCLK_KHZ / kb[r];
		if (f < 2)
			return bt * 175 / 1000;
		if (f == 2)
			return bt * 875 / 10000;
		return (f < 7) ? f : 6;
	endfunction

	task automatic reset_chk;
		nrst = 1'b0;
		pull = 1'b1;
		repeat (6) @(posedge mclk);
		#1 nrst = 1'b1;
		foreach (AD[i])
			rdchk(AD[i], DF[i]);
		check(outs, exp_outs(8'h04, 8'h00, 8'h00, 8'h00));
	endtask

	initial begin
		#500000;
		errors++;
		stop_test();
	end

	initial begin
		void'($urandom(43699));
		reset_chk();
		for (int i = 0; i < 40; i++) begin
			rf = {4'($urandom_range(6)), 1'($urandom), (i == 0) ? 3'h6 : 3'($urandom)};
			cc = {5'h00, 3'($urandom)};
			wk = 8'($urandom);
			lc = 8'($urandom);
			fc = 8'($urandom);
			pull = 1'($urandom);
			wr(`PNFS_ADDR_LIMP_CTRL, lc);
			wr(`PNFS_ADDR_RATE_FILT, rf);
			wr(`PNFS_ADDR_CAN_CFG, cc);
			wr(`PNFS_ADDR_WAKE_CFG, wk);
			wr(`PNFS_ADDR_FS_CNT, fc);
			wr(`PNFS_ADDR_LIMP_STAT, 8'($urandom));
			wr(12'h123, 8'($urandom));
			check(outs, exp_outs(rf, cc, wk, lc));
			rdchk(`PNFS_ADDR_RATE_FILT, rf & 8'hf7);
			rdchk(`PNFS_ADDR_CAN_CFG, cc);
			rdchk(`PNFS_ADDR_WAKE_CFG, wk & 8'h01);
			rdchk(`PNFS_ADDR_FS_CNT, fc & 8'hc0);
			rdchk(`PNFS_ADDR_LIMP_CTRL, lc & 8'h03);
			rdchk(`PNFS_ADDR_LIMP_STAT, {7'h00, (lc[1:0] == 2'h0) ? pull : lc[1]});
			rdchk(12'h123, 8'h00);
		end
		wr(`PNFS_ADDR_LIMP_CTRL, 8'h02);
		pulse(5'b00010);
		rdchk(`PNFS_ADDR_LIMP_CTRL, 8'h00);
		wr(`PNFS_ADDR_LIMP_CTRL, 8'h03);
		wr(`PNFS_ADDR_FS_CNT, 8'h40);
		pulse(5'b00001);
		rdchk(`PNFS_ADDR_LIMP_CTRL, 8'h00);
		rdchk(`PNFS_ADDR_FS_CNT, 8'h80);
		wr(`PNFS_ADDR_LIMP_CTRL, 8'h01);
		pulse(5'b00001);
		pulse(5'b00001);
		rdchk(`PNFS_ADDR_FS_CNT, 8'hc0);
		rdchk(`PNFS_ADDR_LIMP_CTRL, 8'h01);
		pulse(5'b01000);
		rdchk(`PNFS_ADDR_FS_CNT, 8'h00);
		check(outs & 8'h03, 8'h02);
		wr(`PNFS_ADDR_LIMP_CTRL, 8'h03);
		pulse(5'b00100);
		rdchk(`PNFS_ADDR_LIMP_CTRL, 8'h01);
		pulse(5'b10000);
		rdchk(`PNFS_ADDR_LIMP_CTRL, 8'h00);
		wr(`PNFS_ADDR_LIMP_CTRL, 8'h02);
		pulse(5'b11000);
		rdchk(`PNFS_ADDR_LIMP_CTRL, 8'h00);
		r0 = n_rst;
		wr(`PNFS_ADDR_SOFT_RST, 8'h01);
		wr(`PNFS_ADDR_SOFT_RST, 8'h80);
		check({7'h00, srst}, 8'h01);
		wr(`PNFS_ADDR_SOFT_RST, 8'h01);
		rdchk(`PNFS_ADDR_SOFT_RST, 8'h00);
		wr(`PNFS_ADDR_SOFT_RST, 8'h80);
		wr(`PNFS_ADDR_SOFT_RST, 8'h01);
		wr(`PNFS_ADDR_WAKE_CFG, 8'h00);
		wr(`PNFS_ADDR_SOFT_RST, 8'h80);
		wr(`PNFS_ADDR_SOFT_RST, 8'h01);
		wr(`PNFS_ADDR_SOFT_RST, 8'h02);
		wr(`PNFS_ADDR_SOFT_RST, 8'h80);
		repeat (3) @(posedge mclk);
		check(8'(n_rst - r0), 8'h02);
		wr(`PNFS_ADDR_LIMP_CTRL, 8'h03);
		reset_chk();
		for (int f = 0; f < 8; f++) begin
			rf[2:0] = (f < 3) ? 3'($urandom_range(5)) : 3'h4;
			if (f < 3 && rf[2:0] == 3'h5)
				rf[2:0] = 3'h7;
			wr(`PNFS_ADDR_RATE_FILT, {4'(f), 1'b0, rf[2:0]});
			burst(limit(f, int'(rf[2:0])) + 2, (f < 7) ? 1 : 0);
			burst(limit(f, int'(rf[2:0])), 0);
		end
		wr(`PNFS_ADDR_RATE_FILT, 8'h36);
		burst(10, 0);
		stop_test();
	end
endmodule

// ==== test/pnfs_pin_model.sv ====
/*
 Far-side model: limp pin load and a bus node sending dominant pulses.
 Assumes the bench requests one pulse at a time on mclk.
*/
`timescale 1ns/10ps

module pnfs_pin_model (
	input  wire logic       mclk,     // System clock
	input  wire logic       nrst,     // Async reset, active low
	input  wire logic       go,       // Start one dominant pulse
	input  wire logic [8:0] dom_clks, // Pulse length in clocks
	input  wire logic       pin_out,  // Limp pin value from the block
	input  wire logic       pin_oe,   // Limp pin enable from the block
	input  wire logic       pull_lvl, // External load level when undriven
	output logic            limp_lvl, // Sensed limp pin level
	output logic            rxd       // Bus receive line, low dominant
);
	logic [8:0] cnt_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			cnt_reg <= '0;
		else if (go)
			cnt_reg <= dom_clks;
		else if (cnt_reg != 9'h000)
			cnt_reg <= cnt_reg - 9'h001;
	end

	// Bus stays recessive between pulses
	assign rxd      = cnt_reg == 9'h000;
	assign limp_lvl = pin_oe ? pin_out : pull_lvl;
endmodule
